// ### shared/pflc_pkg.sv
// package: constants and carrier types for the power-fail lockout control
package pflc_pkg;

	localparam int          CLK_HZ           = 40_000_000;
	localparam int          TICK_NS          = 1000;
	localparam int          TICK_CYC         = TICK_NS / (1_000_000_000 / CLK_HZ);
	localparam int          DEBOUNCE_MIN_US  = 30;
	localparam int          DEBOUNCE_MAX_US  = 63;
	localparam int          DEBOUNCE_TICKS   = 31;
	localparam int          SAFETY_US        = 30;
	localparam int          SAFETY_TICKS     = SAFETY_US + 1;
	localparam int          DELAY_US         = 480;
	localparam int          DELAY_TICKS      = DELAY_US;
	localparam int          CNT_W            = 9;
	localparam int          TICK_W           = 6;

	localparam logic        RST_OSC_FAIL     = 1'b1;
	localparam logic        RST_RTC_START    = 1'b0;
	localparam logic        RST_TIME_SAVE_EN = 1'b0;

	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_FAILDB = 2'b01,
		ST_LOCKED = 2'b11,
		ST_RISEDB = 2'b10
	} pflc_state_type;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
	} pflc_host_type;

	typedef struct packed {
		logic pf_int_en;
		logic delay_en;
		logic timer_pf_op;
		logic int_pf_op;
		logic single_supply;
	} pflc_cfg_type;

	typedef struct packed {
		logic power_failing;
		logic locked_out;
		logic standby;
		logic osc_fail;
		logic rtc_start;
		logic low_battery;
		logic time_save_en;
		logic save_copy;
		logic timers_run;
		logic ints_run;
		logic outputs_od;
		logic batt_ref_on;
	} pflc_stat_type;

endpackage : pflc_pkg

// ### src/pflc_tick.sv
// oscillator-derived 1 us periodic tick generator
`timescale 1ns/1ps
module pflc_tick
	import pflc_pkg::*;
#(
	parameter int DIV = TICK_CYC
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// tick out
	output logic      tick
);
	typedef struct packed {
		logic [TICK_W-1:0] cnt;
		logic              tick;
	} pflc_tick_state_type;

	pflc_tick_state_type r;
	pflc_tick_state_type next_r;

	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (r.cnt == TICK_W'(DIV - 1)) begin
			next_r.cnt = '0;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick = r.tick;
endmodule : pflc_tick

// ### src/pflc_power_fail_lockout_control.sv
// power-fail supervision, bus lockout, supply status and time-save control
//
// Summary of operation
// - low power_fail_n counts as failure only after 30-63 us debounce
// - debounce expiry raises power-failing, plus a power-fail interrupt event when enabled on main supply
// - without delay option, bus isolated 30-63 us after power_fail_n low
// - lockout-delay enable bit postpones lockout; device honours it
// - strobe held over 30 us after failure while selected forces lockout
// - with delay enabled, bus stays usable 480 us then locks out
// - clearing delay enable in the window locks out immediately
// - supply switchover follows supply comparator only, not power_fail_n
// - locked or standby: host pins ignored; outputs open drain in standby
// - two mode bits choose whether timers and interrupts run after failure
// - stays locked while input low; unlock after 30-63 us high debounce
// - masked interrupt still locks out but issues no external interrupt
// - first power-up sets oscillator-fail and clears clock start
// - oscillator-fail stays set until clock started, then clears
// - write of 0 to flag bit leaves oscillator-fail unchanged; write of 1 sets it
// - low-battery set only on main supply with battery comparator low
// - interrupt enable low disables power-fail interrupt and low-battery detection
// - time-save enable set copies live clock into save storage
// - time-save enable cleared on battery switch or software write
// - single-supply bit disables oscillator battery reference
// - power-fail interrupt reaches output only when enabled
// - power-fail status follows failure signal, clears on restore only
// - lockout held off while selected with a strobe, until the safety limit
`timescale 1ns/1ps
module pflc_power_fail_lockout_control
	import pflc_pkg::*;
#(
	parameter int DB_TICKS    = DEBOUNCE_TICKS,
	parameter int SAFE_TICKS  = SAFETY_TICKS,
	parameter int DLY_TICKS   = DELAY_TICKS
) (
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          arst_n,
	// supply and comparator inputs
	input  wire logic          power_fail_n,
	input  wire logic          vcc_below_battery,
	input  wire logic          battery_low_cmp,
	// host bus strobes and data enable request
	input  pflc_host_type      host,
	input  wire logic          host_data_oe_req,
	// software control bits
	input  pflc_cfg_type       cfg,
	input  wire logic          rtc_start_set,
	input  wire logic          rtc_start_clr,
	input  wire logic          osc_flag_wr,
	input  wire logic          osc_flag_wdata,
	input  wire logic          time_save_set,
	input  wire logic          time_save_clr,
	// gated host bus
	output logic               host_cs_act,
	output logic               host_rd_act,
	output logic               host_wr_act,
	output logic               host_data_oe,
	// interrupt and status
	output logic               pf_irq,
	output logic               pf_event,
	output pflc_stat_type      stat
);
	typedef struct packed {
		pflc_state_type      st;
		logic [CNT_W-1:0]    cnt;
		logic [CNT_W-1:0]    dly;
		logic [5:0]          safe;
		logic                dly_run;
		logic                failing;
		logic                locked;
		logic                pf_irq;
		logic                pf_event;
		logic                cs_act;
		logic                rd_act;
		logic                wr_act;
		logic                d_oe;
		pflc_stat_type       stat;
	} pflc_core_type;

	pflc_core_type r;
	pflc_core_type next_r;
	logic          tick;

	////////////////////////////////////////////////////////////////////////
	pflc_tick u_tick (
		.mclk   (mclk),
		.arst_n (arst_n),
		.tick   (tick)
	);

	function automatic logic strobe_on(input pflc_host_type h);
		strobe_on = !h.cs_n && (!h.rd_n || !h.wr_n);
	endfunction : strobe_on

	// both debounce directions share one length
	function automatic logic db_expired(input logic [CNT_W-1:0] c);
		db_expired = (c == CNT_W'(DB_TICKS));
	endfunction : db_expired

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic detect_on;
		logic in_access;
		logic fail_now;
		logic lock_now;
		// live supply input, so status never lags a switch to standby
		detect_on = cfg.pf_int_en && !vcc_below_battery;
		in_access = strobe_on(host);
		fail_now  = 1'b0;
		lock_now  = r.locked;
		next_r    = r;
		next_r.pf_event = 1'b0;

		// input debounce in both directions
		case (r.st)
			ST_RUN: begin
				next_r.cnt = '0;
				if (!power_fail_n) begin
					next_r.st = ST_FAILDB;
				end
			end
			ST_FAILDB: begin
				if (power_fail_n) begin
					next_r.st = ST_RUN;
				end else if (tick) begin
					if (db_expired(r.cnt)) begin
						next_r.st = ST_LOCKED;
						fail_now  = 1'b1;
					end else begin
						next_r.cnt = r.cnt + 1'b1;
					end
				end
			end
			ST_LOCKED: begin
				next_r.cnt = '0;
				if (power_fail_n) begin
					next_r.st = ST_RISEDB;
				end
			end
			ST_RISEDB: begin
				if (!power_fail_n) begin
					next_r.st = ST_LOCKED;
				end else if (tick) begin
					if (db_expired(r.cnt)) begin
						next_r.st = ST_RUN;
					end else begin
						next_r.cnt = r.cnt + 1'b1;
					end
				end
			end
			default: begin
				next_r.st = ST_RUN;
			end
		endcase

		// power-failing indication and event
		if (fail_now) begin
			next_r.failing  = 1'b1;
			next_r.pf_event = detect_on;
			next_r.dly_run  = cfg.delay_en;
			next_r.dly      = '0;
			next_r.safe     = '0;
		end
		if (next_r.st == ST_RUN && r.st == ST_RISEDB) begin
			next_r.failing = 1'b0;
			next_r.dly_run = 1'b0;
			lock_now       = 1'b0;
		end

		// lockout decision, held off during an ordinary access
		// a restore in this cycle must not lock the bus again
		if (r.failing && next_r.failing && !r.locked) begin
			if (r.dly_run) begin
				if (!cfg.delay_en) begin
					next_r.dly_run = 1'b0;
				end else if (tick) begin
					next_r.dly = r.dly + 1'b1;
					if (r.dly == CNT_W'(DLY_TICKS - 1)) begin
						next_r.dly_run = 1'b0;
					end
				end
			end
			if (in_access && tick && r.safe != 6'(SAFE_TICKS)) begin
				next_r.safe = r.safe + 1'b1;
			end else if (!in_access) begin
				next_r.safe = '0;
			end
			if (!r.dly_run && !in_access) begin
				lock_now = 1'b1;
			end
			if (r.safe == 6'(SAFE_TICKS)) begin
				lock_now = 1'b1;
			end
		end
		next_r.locked = lock_now;

		// supply switchover and pin isolation
		next_r.stat.standby    = vcc_below_battery;
		next_r.stat.outputs_od = vcc_below_battery;
		next_r.cs_act = !host.cs_n && !lock_now && !vcc_below_battery;
		next_r.rd_act = next_r.cs_act && !host.rd_n;
		next_r.wr_act = next_r.cs_act && !host.wr_n;
		next_r.d_oe   = next_r.rd_act && host_data_oe_req;

		// interrupt routing
		next_r.pf_irq = next_r.failing && detect_on;

		// operation after failure
		next_r.stat.timers_run = !next_r.failing || cfg.timer_pf_op;
		next_r.stat.ints_run   = !next_r.failing || cfg.int_pf_op;

		// oscillator fail and clock start
		if (rtc_start_clr) begin
			next_r.stat.rtc_start = 1'b0;
		end
		if (rtc_start_set) begin
			next_r.stat.rtc_start = 1'b1;
			next_r.stat.osc_fail  = 1'b0;
		end else if (osc_flag_wr && osc_flag_wdata) begin
			next_r.stat.osc_fail = 1'b1;
		end
		next_r.stat.batt_ref_on = !cfg.single_supply;

		// low battery, main supply only
		next_r.stat.low_battery = detect_on && battery_low_cmp;

		// time save
		if (time_save_set) begin
			next_r.stat.time_save_en = 1'b1;
		end
		if (time_save_clr || (vcc_below_battery && !r.stat.standby)) begin
			next_r.stat.time_save_en = 1'b0;
		end
		next_r.stat.save_copy = next_r.stat.time_save_en;

		next_r.stat.power_failing = next_r.failing;
		next_r.stat.locked_out    = lock_now || vcc_below_battery;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			r                   <= '0;
			r.st                <= ST_RUN;
			r.stat.osc_fail     <= RST_OSC_FAIL;
			r.stat.rtc_start    <= RST_RTC_START;
			r.stat.time_save_en <= RST_TIME_SAVE_EN;
			r.stat.timers_run   <= 1'b1;
			r.stat.ints_run     <= 1'b1;
			r.stat.batt_ref_on  <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign host_cs_act  = r.cs_act;
	assign host_rd_act  = r.rd_act;
	assign host_wr_act  = r.wr_act;
	assign host_data_oe = r.d_oe;
	assign pf_irq       = r.pf_irq;
	assign pf_event     = r.pf_event;
	assign stat         = r.stat;
endmodule : pflc_power_fail_lockout_control

// ### tb/pflc_props.sv
// assertion checker for the power-fail lockout control
`timescale 1ns/1ps
module pflc_props
	import pflc_pkg::*;
#(
	parameter int DB_TICKS = DEBOUNCE_TICKS
) (
	// clock, reset and inputs
	input wire logic     mclk,
	input wire logic     arst_n,
	input wire logic     power_fail_n,
	input wire logic     vcc_below_battery,
	input pflc_host_type host,
	input pflc_cfg_type  cfg,
	input wire logic     rtc_start_set,
	input wire logic     osc_flag_wr,
	input wire logic     osc_flag_wdata,
	// outputs
	input wire logic     host_cs_act,
	input wire logic     host_rd_act,
	input wire logic     host_wr_act,
	input wire logic     host_data_oe,
	input wire logic     pf_irq,
	input wire logic     pf_event,
	input pflc_stat_type stat
);
	int low_cnt;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n) low_cnt <= 0;
		else low_cnt <= power_fail_n ? 0 : low_cnt + 1;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_fail_prompt;
		$rose(stat.power_failing) && !cfg.delay_en && host.cs_n;
	endsequence
	AST_DEBOUNCE: assert property ($rose(stat.power_failing) |->
		low_cnt >= DB_TICKS * TICK_CYC && low_cnt <= (DB_TICKS + 3) * TICK_CYC)
		else $error("debounce length wrong");
	AST_EVENT: assert property (pf_event |-> stat.power_failing ##1 !pf_event)
		else $error("fail event wrong");
	AST_PROMPT: assert property (s_fail_prompt |-> ##[1:2] stat.locked_out)
		else $error("prompt lockout missing");
	AST_IRQ_MASK: assert property (pf_irq |-> $past(cfg.pf_int_en))
		else $error("masked interrupt seen");
	AST_LOCK_REFUSE: assert property (stat.locked_out && $past(stat.locked_out)
		|-> !host_cs_act && !host_data_oe) else $error("access while locked");
	AST_STANDBY: assert property ($past(vcc_below_battery) |-> !(host_rd_act || host_wr_act))
		else $error("access in standby");
	AST_OSC_CLR: assert property ($past(rtc_start_set) && !$past(osc_flag_wr)
		|-> !stat.osc_fail) else $error("osc flag not cleared");
	AST_OSC_KEEP: assert property ($past(osc_flag_wr) && !$past(osc_flag_wdata)
		&& !$past(rtc_start_set) |-> $stable(stat.osc_fail)) else $error("osc flag changed");
	AST_TSAVE: assert property ($rose(vcc_below_battery) |-> ##[1:2] !stat.time_save_en)
		else $error("time save not cleared");
	AST_LOWBAT: assert property (stat.low_battery
		|-> $past(cfg.pf_int_en && !vcc_below_battery)) else $error("low battery wrong");
endmodule : pflc_props
bind pflc_power_fail_lockout_control pflc_props #(.DB_TICKS(DB_TICKS)) u_props (.mclk, .arst_n,
	.power_fail_n, .vcc_below_battery, .host, .cfg, .rtc_start_set, .osc_flag_wr,
	.osc_flag_wdata, .host_cs_act, .host_rd_act, .host_wr_act, .host_data_oe, .pf_irq,
	.pf_event, .stat);

// ### tb/pflc_host_model.sv
// host processor model driving the bus strobes
`timescale 1ns/1ps
module pflc_host_model
	import pflc_pkg::*;
(
	// clock
	input  wire logic    mclk,
	// access wanted by the bench
	input  wire logic    want_rd,
	input  wire logic    want_wr,
	// strobes to the device
	output pflc_host_type host
);
	// strobes launch just after the rising edge, so the device sees a new
	// request one edge later and never races the bench's falling-edge writes
	initial host = '1;
	always @(posedge mclk) begin
		host.cs_n <= !(want_rd || want_wr);
		host.rd_n <= !want_rd;
		host.wr_n <= !want_wr;
	end
endmodule : pflc_host_model

// ### tb/test_power_fail_lockout_control.sv
// self-checking bench for the power-fail lockout control
`timescale 1ns/1ps
module test_power_fail_lockout_control
	import pflc_pkg::*;
;
	localparam int DB = 3, SF = 4, DL = 10, TK = TICK_CYC;
	logic mclk = 0, arst_n = 0, power_fail_n = 1, vcc_below_battery = 0, battery_low_cmp = 0;
	logic host_data_oe_req = 0, rtc_start_set = 0, rtc_start_clr = 0, osc_flag_wr = 0;
	logic osc_flag_wdata = 0, time_save_set = 0, time_save_clr = 0, want_rd = 0, want_wr = 0;
	logic host_cs_act, host_rd_act, host_wr_act, host_data_oe, pf_irq, pf_event;
	pflc_host_type host;
	pflc_cfg_type  cfg = 5'h10;
	pflc_stat_type stat;
	int miscompares = 0, compares = 0;
	int pf_events = 0;
	// {rd, wr, standby, oe_req, cs_act, rd_act, wr_act, data_oe}
	logic [7:0] rows [5] = '{8'h00, 8'h9D, 8'h4A, 8'hB0, 8'h60};
	pflc_power_fail_lockout_control #(.DB_TICKS(DB), .SAFE_TICKS(SF), .DLY_TICKS(DL)) u_dut (
		.mclk, .arst_n, .power_fail_n, .vcc_below_battery, .battery_low_cmp, .host,
		.host_data_oe_req, .cfg, .rtc_start_set, .rtc_start_clr, .osc_flag_wr, .osc_flag_wdata,
		.time_save_set, .time_save_clr, .host_cs_act, .host_rd_act, .host_wr_act,
		.host_data_oe, .pf_irq, .pf_event, .stat);
	pflc_host_model u_host (.mclk, .want_rd, .want_wr, .host);
	// one-cycle event pulses are counted on the edge after they launch
	always @(posedge mclk) pf_events <= pf_events + pf_event;
	initial forever #12.5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string name, input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
		end
	endtask : chk
	task stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	task cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	// sel 1 waits on power_failing, 0 on locked_out
	task wait_for(input bit sel, input logic v, input int lim);
		for (int i = 0; i < lim && (sel ? stat.power_failing : stat.locked_out) !== v; i++)
			cyc(1);
		chk("wait", sel ? stat.power_failing : stat.locked_out, v);
		if (miscompares != 0) stop_test();
	endtask : wait_for
	task fail(input bit sel);
		power_fail_n = 0;
		wait_for(sel, 1, (DB + 3) * TK);
	endtask : fail
	task restore;
		power_fail_n = 1;
		cyc(2 * TK);
		chk("still locked", stat.locked_out, 1);
		wait_for(0, 0, (DB + 3) * TK);
		chk("failing", stat.power_failing, 0);
	endtask : restore
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(3);
		chk("osc_fail", stat.osc_fail, RST_OSC_FAIL);
		chk("rtc_start", stat.rtc_start, RST_RTC_START);
		cyc(2);
		arst_n = 1;
		cyc(2);
		foreach (rows[i]) begin
			{want_rd, want_wr, vcc_below_battery, host_data_oe_req} = rows[i][7:4];
			cyc(3);
			chk("cs", host_cs_act, rows[i][3]);
			chk("rd", host_rd_act, rows[i][2]);
			chk("wr", host_wr_act, rows[i][1]);
			chk("oe", host_data_oe, rows[i][0]);
		end
		{want_rd, want_wr, vcc_below_battery, host_data_oe_req} = '0;
		osc_flag_wr = 1;
		cyc(1);
		osc_flag_wr = 0;
		cyc(1);
		chk("osc keep", stat.osc_fail, 1);
		rtc_start_set = 1;
		cyc(1);
		rtc_start_set = 0;
		cyc(1);
		chk("osc clr", stat.osc_fail, 0);
		chk("rtc start", stat.rtc_start, 1);
		time_save_set = 1;
		cyc(1);
		time_save_set = 0;
		cyc(1);
		chk("save copy", stat.save_copy, 1);
		vcc_below_battery = 1;
		cyc(3);
		chk("save off", stat.time_save_en, 0);
		chk("open drain", stat.outputs_od, 1);
		vcc_below_battery = 0;
		battery_low_cmp = 1;
		cyc(3);
		chk("low batt", stat.low_battery, 1);
		vcc_below_battery = 1;
		cfg.single_supply = 1;
		cyc(3);
		chk("low batt standby", stat.low_battery, 0);
		chk("standby", stat.standby, 1);
		chk("batt ref", stat.batt_ref_on, 0);
		{vcc_below_battery, battery_low_cmp, cfg.single_supply} = '0;
		// short glitch stays below the debounce
		power_fail_n = 0;
		cyc(DB * TK - 10);
		power_fail_n = 1;
		cyc(DB * TK);
		chk("glitch", stat.power_failing, 0);
		fail(1);
		chk("irq", pf_irq, 1);
		want_rd = 1;
		cyc(3);
		chk("locked", stat.locked_out, 1);
		chk("event", pf_events == 1, 1);
		chk("timers off", stat.timers_run, 0);
		chk("ints off", stat.ints_run, 0);
		chk("rd locked", host_rd_act, 0);
		want_rd = 0;
		restore();
		cfg.pf_int_en = 0;
		fail(0);
		chk("masked irq", pf_irq, 0);
		chk("masked event", pf_events == 1, 1);
		restore();
		cfg = 5'h1E;
		fail(1);
		chk("timers on", stat.timers_run, 1);
		chk("ints on", stat.ints_run, 1);
		want_wr = 1;
		cyc(3);
		chk("window wr", host_wr_act, 1);
		chk("event two", pf_events == 2, 1);
		want_wr = 0;
		cyc((DL - 2) * TK);
		chk("window", stat.locked_out, 0);
		wait_for(0, 1, 4 * TK);
		restore();
		fail(1);
		cyc(TK);
		chk("early open", stat.locked_out, 0);
		cfg.delay_en = 0;
		cyc(3);
		chk("early end", stat.locked_out, 1);
		restore();
		want_rd = 1;
		cyc(3);
		fail(1);
		chk("held access", stat.locked_out, 0);
		wait_for(0, 1, (SF + 2) * TK);
		want_rd = 0;
		restore();
		// second reset in mid-run brings the power-up flags back
		arst_n = 0;
		cyc(2);
		chk("reset osc", stat.osc_fail, RST_OSC_FAIL);
		chk("reset start", stat.rtc_start, RST_RTC_START);
		arst_n = 1;
		cyc(2);
		stop_test();
	end
endmodule : test_power_fail_lockout_control
